// File: rtl/port_b_gpio.sv
// module: eight-bit bidirectional port with weak pull-ups, analog select and change detection
// ------------------------------------------------------------
// Notes on behaviour
// - eight pins, direction, latch, readable value
// - direction bit one releases the driver
// - direction bit zero drives latch onto pin
// - latch readable separately, returns latch contents
// - global pull-up control bit, cleared enables
// - outputs never get a pull-up
// - every reset disables pull-ups
// - power-on: low five analog, reading zero
// - config bit cleared makes low five digital
// - only upper input pins join comparison
// - snapshot upper pins on each port read
// - mismatches ORed into port-change flag
// - port change can wake from sleep
// - port access ends mismatch, except move
// - persisting mismatch keeps setting the flag
// - analog pins read digitally as low
// - pull-up only in plain input mode
// - enabled can transmit owns pin two
// - programming entry disables pin five driver
// ------------------------------------------------------------
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module port_b_gpio (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic powerOnReset,
	input wire logic [7:0] configByteThreeHigh,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic memMoveAccess,
	output logic [7:0] regRdData,
	// pins
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe,
	output logic [7:0] pullupEn,
	// peripheral overrides
	input wire logic canEnable,
	input wire logic canTransmitPin,
	input wire logic lowVoltageProgEntry,
	// requests to the core
	output logic portChangeIrq,
	output logic portChangeWake,
	output logic portChangePriority
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] analogMask(input logic [3:0] pcfg);
		analogMask = {3'h0,
			pcfg <= port_b_pkg::ANALOG_LIMIT_PIN4,
			pcfg <= port_b_pkg::ANALOG_LIMIT_PIN3,
			pcfg <= port_b_pkg::ANALOG_LIMIT_PIN2,
			pcfg <= port_b_pkg::ANALOG_LIMIT_PIN1,
			pcfg <= port_b_pkg::ANALOG_LIMIT_PIN0};
	endfunction : analogMask

	function automatic logic isAccess(input logic [3:0] addr, input logic [3:0] ofs, input logic strobe);
		isAccess = strobe && (addr == ofs);
	endfunction : isAccess

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	logic [7:0] pinMeta_r;
	logic [7:0] pinSync_r;

	always_ff @(posedge clk) begin
		pinMeta_r <= pinIn;
		pinSync_r <= pinMeta_r;
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] latch_r, latch_nxt;
	logic [7:0] dir_r, dir_nxt;
	logic changeEnable_r, changeEnable_nxt;
	logic changeFlag_r, changeFlag_nxt;
	logic pullupDisableN_r, pullupDisableN_nxt;
	logic priority_r, priority_nxt;
	logic [3:0] pcfg_r, pcfg_nxt;
	logic [1:0] vcfg_r, vcfg_nxt;
	logic [3:0] snapshot_r, snapshot_nxt;
	logic [7:0] rdData_r, rdData_nxt;

	logic [7:0] analogSel;
	logic [7:0] pinRead;
	logic [7:0] override;
	logic [3:0] mismatch;
	logic portChange;
	logic portAccess;
	logic [3:0] pcfgAtReset;

	// ------------------------------------------------------------
	// pin side
	// ------------------------------------------------------------
	always_comb begin
		analogSel = analogMask(pcfg_r);
		pinRead = pinSync_r & ~analogSel;
		override = 8'h00;
		override[port_b_pkg::CAN_TRANSMIT_PIN] = canEnable;
		override[port_b_pkg::LOW_VOLTAGE_PROG_ENTRY_PIN] = lowVoltageProgEntry;
		pinOut = latch_r;
		pinOe = ~dir_r;
		// the can transmitter wins over the direction bit
		pinOut[port_b_pkg::CAN_TRANSMIT_PIN] = canEnable ? canTransmitPin
			: latch_r[port_b_pkg::CAN_TRANSMIT_PIN];
		if (canEnable) begin
			pinOe[port_b_pkg::CAN_TRANSMIT_PIN] = 1'b1;
		end
		if (lowVoltageProgEntry) begin
			pinOe[port_b_pkg::LOW_VOLTAGE_PROG_ENTRY_PIN] = 1'b0;
		end
		// pull-ups only for plain inputs, and off while the global bit is set
		pullupEn = pullupDisableN_r ? 8'h00 : (dir_r & ~override);
	end

	// ------------------------------------------------------------
	// change detection
	// ------------------------------------------------------------
	always_comb begin
		// pins driven as outputs are masked out of the compare
		mismatch = (pinRead[7:port_b_pkg::CHANGE_LOW_PIN] ^ snapshot_r)
			& dir_r[7:port_b_pkg::CHANGE_LOW_PIN];
		portChange = |mismatch;
		portChangeIrq = changeFlag_r && changeEnable_r;
		// wake does not depend on the core running, so it is the same level
		portChangeWake = changeFlag_r && changeEnable_r;
		portChangePriority = priority_r;
	end

	// ------------------------------------------------------------
	// register next values
	// ------------------------------------------------------------
	always_comb begin
		latch_nxt = latch_r;
		dir_nxt = dir_r;
		changeEnable_nxt = changeEnable_r;
		changeFlag_nxt = changeFlag_r;
		pullupDisableN_nxt = pullupDisableN_r;
		priority_nxt = priority_r;
		pcfg_nxt = pcfg_r;
		vcfg_nxt = vcfg_r;
		snapshot_nxt = snapshot_r;
		rdData_nxt = 8'h00;
		portAccess = 1'b0;

		// writes
		if (regWr) begin
			unique case (regAddr)
				port_b_pkg::OFS_PIN_VALUE,
				port_b_pkg::OFS_OUTPUT_LATCH: begin
					latch_nxt = regWrData;
				end
				port_b_pkg::OFS_DIRECTION_CONTROL: begin
					dir_nxt = regWrData;
				end
				port_b_pkg::OFS_INTERRUPT_CONTROL_PRIMARY: begin
					changeEnable_nxt = regWrData[port_b_pkg::PORT_CHANGE_ENABLE_BIT];
					changeFlag_nxt = regWrData[port_b_pkg::PORT_CHANGE_FLAG_BIT];
				end
				port_b_pkg::OFS_INTERRUPT_CONTROL_SECOND: begin
					pullupDisableN_nxt = regWrData[port_b_pkg::PULLUP_DISABLE_N_BIT];
					priority_nxt = regWrData[port_b_pkg::PORT_CHANGE_PRIORITY_BIT];
				end
				port_b_pkg::OFS_ANALOG_PIN_CONFIG: begin
					pcfg_nxt = regWrData[port_b_pkg::PCFG_MSB:0];
					vcfg_nxt = regWrData[port_b_pkg::VCFG_MSB:port_b_pkg::PCFG_MSB + 1];
				end
				default: begin
				end
			endcase
		end

		// reads, answered in the next cycle; unmapped offsets read zero
		if (regRd) begin
			unique case (regAddr)
				port_b_pkg::OFS_PIN_VALUE: rdData_nxt = pinRead;
				port_b_pkg::OFS_OUTPUT_LATCH: rdData_nxt = latch_r;
				port_b_pkg::OFS_DIRECTION_CONTROL: rdData_nxt = dir_r;
				port_b_pkg::OFS_INTERRUPT_CONTROL_PRIMARY: begin
					rdData_nxt[port_b_pkg::PORT_CHANGE_ENABLE_BIT] = changeEnable_r;
					rdData_nxt[port_b_pkg::PORT_CHANGE_FLAG_BIT] = changeFlag_r;
				end
				port_b_pkg::OFS_INTERRUPT_CONTROL_SECOND: begin
					rdData_nxt[port_b_pkg::PULLUP_DISABLE_N_BIT] = pullupDisableN_r;
					rdData_nxt[port_b_pkg::PORT_CHANGE_PRIORITY_BIT] = priority_r;
				end
				port_b_pkg::OFS_ANALOG_PIN_CONFIG: begin
					rdData_nxt = {2'h0, vcfg_r, pcfg_r};
				end
				default: rdData_nxt = 8'h00;
			endcase
		end

		// any port access resyncs the snapshot; a memory move into the port does not
		portAccess = (isAccess(regAddr, port_b_pkg::OFS_PIN_VALUE, regRd)
			|| (isAccess(regAddr, port_b_pkg::OFS_PIN_VALUE, regWr) && !memMoveAccess));
		if (portAccess) begin
			snapshot_nxt = pinRead[7:port_b_pkg::CHANGE_LOW_PIN];
		end

		// the mismatch keeps setting the flag, so it beats a software clear
		if (portChange && !portAccess) begin
			changeFlag_nxt = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	assign pcfgAtReset = configByteThreeHigh[port_b_pkg::LOW_PINS_ANALOG_AT_POR_BIT]
		? port_b_pkg::RST_PCFG_ANALOG : port_b_pkg::RST_PCFG_DIGITAL;

	always_ff @(posedge clk) begin
		if (srst) begin
			latch_r <= port_b_pkg::RST_OUTPUT_LATCH;
			dir_r <= port_b_pkg::RST_DIRECTION_CONTROL;
			changeEnable_r <= 1'b0;
			changeFlag_r <= 1'b0;
			pullupDisableN_r <= port_b_pkg::RST_PULLUP_DISABLE_N;
			priority_r <= port_b_pkg::RST_PORT_CHANGE_PRIORITY;
			snapshot_r <= 4'h0;
			rdData_r <= 8'h00;
			// converter setting survives warm resets; only power-on reloads it
			if (powerOnReset) begin
				pcfg_r <= pcfgAtReset;
				vcfg_r <= port_b_pkg::RST_VCFG;
			end
		end else begin
			latch_r <= latch_nxt;
			dir_r <= dir_nxt;
			changeEnable_r <= changeEnable_nxt;
			changeFlag_r <= changeFlag_nxt;
			pullupDisableN_r <= pullupDisableN_nxt;
			priority_r <= priority_nxt;
			pcfg_r <= pcfg_nxt;
			vcfg_r <= vcfg_nxt;
			snapshot_r <= snapshot_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	assign regRdData = rdData_r;
endmodule : port_b_gpio

// File: rtl/port_b_pkg.sv
// package: register map, field positions and reset values of the port b block
package port_b_pkg;
	// ------------------------------------------------------------
	// register offsets (register index on the plain port)
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_PIN_VALUE = 4'h0;
	localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h1;
	localparam logic [3:0] OFS_DIRECTION_CONTROL = 4'h2;
	localparam logic [3:0] OFS_INTERRUPT_CONTROL_PRIMARY = 4'h3;
	localparam logic [3:0] OFS_INTERRUPT_CONTROL_SECOND = 4'h4;
	localparam logic [3:0] OFS_INTERRUPT_CONTROL_THIRD = 4'h5;
	localparam logic [3:0] OFS_ANALOG_PIN_CONFIG = 4'h6;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PORT_CHANGE_FLAG_BIT = 0;
	localparam int PORT_CHANGE_ENABLE_BIT = 3;
	localparam int PULLUP_DISABLE_N_BIT = 7;
	localparam int PORT_CHANGE_PRIORITY_BIT = 0;
	localparam int LOW_PINS_ANALOG_AT_POR_BIT = 1;
	localparam int CAN_TRANSMIT_PIN = 2;
	localparam int LOW_VOLTAGE_PROG_ENTRY_PIN = 5;
	localparam int CHANGE_LOW_PIN = 4;
	localparam int PCFG_MSB = 3;
	localparam int VCFG_MSB = 5;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
	localparam logic [7:0] RST_DIRECTION_CONTROL = 8'hff;
	localparam logic RST_PULLUP_DISABLE_N = 1'b1;
	localparam logic RST_PORT_CHANGE_PRIORITY = 1'b1;
	localparam logic [3:0] RST_PCFG_ANALOG = 4'h0;
	localparam logic [3:0] RST_PCFG_DIGITAL = 4'hf;
	localparam logic [1:0] RST_VCFG = 2'h0;

	// ------------------------------------------------------------
	// highest converter setting that still leaves each low pin analog
	// ------------------------------------------------------------
	localparam logic [3:0] ANALOG_LIMIT_PIN0 = 4'h4;
	localparam logic [3:0] ANALOG_LIMIT_PIN1 = 4'h6;
	localparam logic [3:0] ANALOG_LIMIT_PIN2 = 4'h4;
	localparam logic [3:0] ANALOG_LIMIT_PIN3 = 4'h4;
	localparam logic [3:0] ANALOG_LIMIT_PIN4 = 4'h5;
endpackage : port_b_pkg

// File: verification/keypad_model.sv
// partner: keypad switches and external drivers on the eight pins
`timescale 1ns/1ps
module keypad_model (
	// clock
	input wire logic clk,
	// block side
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] pullupEn,
	// stimulus side: a pressed key drives 0
	input wire logic [7:0] extEn,
	input wire logic [7:0] extVal,
	// pin levels
	output logic [7:0] pinIn
);
	// an undriven pin without pull-up toggles, so a floating input never reads as a steady value
	logic [7:0] floatLvl_r = 8'h55;
	always @(posedge clk) floatLvl_r <= ~floatLvl_r;
	always_comb pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & (pullupEn | floatLvl_r & ~pullupEn));
endmodule : keypad_model

// File: verification/port_b_monitor.sv
// checker: concurrent properties on the port b block pins and register port
`timescale 1ns/1ps
module port_b_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	// pins and overrides
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] pullupEn,
	input wire logic canEnable,
	input wire logic canTransmitPin,
	input wire logic lowVoltageProgEntry,
	// requests
	input wire logic portChangeIrq,
	input wire logic portChangeWake
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// pins 2 and 5 are masked: peripherals may own them
	property p_dir; regWr && regAddr == port_b_pkg::OFS_DIRECTION_CONTROL |=> (pinOe & 8'hdb) == (~$past(regWrData) & 8'hdb); endproperty
	a_dir: assert property (p_dir) else $error("direction write not seen on pin enables");
	property p_lat; regWr && regAddr == port_b_pkg::OFS_OUTPUT_LATCH |=> (pinOut & 8'hfb) == ($past(regWrData) & 8'hfb); endproperty
	a_lat: assert property (p_lat) else $error("latch write not seen on pin drive");
	property p_latrd; regRd && regAddr == port_b_pkg::OFS_OUTPUT_LATCH && !canEnable |=> regRdData == $past(pinOut); endproperty
	a_latrd: assert property (p_latrd) else $error("latch read differs from drive value");
	property p_idle; !regRd |=> regRdData == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside its cycle");
	property p_outpull; (pullupEn & pinOe) == 8'h00; endproperty
	a_outpull: assert property (p_outpull) else $error("pull-up on a driven pin");
	property p_rstpull; $fell(srst) |-> pullupEn == 8'h00; endproperty
	a_rstpull: assert property (p_rstpull) else $error("pull-ups on after reset");
	property p_can; canEnable |-> pinOe[2] && pinOut[2] == canTransmitPin; endproperty
	a_can: assert property (p_can) else $error("transmitter does not own pin 2");
	property p_lvp; lowVoltageProgEntry |-> !pinOe[5] && !pullupEn[5]; endproperty
	a_lvp: assert property (p_lvp) else $error("pin 5 driven during programming entry");
	property p_hold;
		$fell(portChangeIrq) |-> ($past(regWr) && $past(regAddr) == port_b_pkg::OFS_INTERRUPT_CONTROL_PRIMARY)
			|| $past(srst);
	endproperty
	a_hold: assert property (p_hold) else $error("change request dropped without a clear");
	property p_wake; portChangeWake == portChangeIrq; endproperty
	a_wake: assert property (p_wake) else $error("wake differs from change request");
	c_irq: cover property ($rose(portChangeIrq));
	c_clr: cover property ($fell(portChangeIrq));
	c_can: cover property (canEnable && lowVoltageProgEntry);
endmodule : port_b_monitor
bind port_b_gpio port_b_monitor port_b_monitor_i (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
	.pinOut, .pinOe, .pullupEn, .canEnable, .canTransmitPin, .lowVoltageProgEntry, .portChangeIrq, .portChangeWake);

// File: verification/tb_top.sv
// testbench: self-checking regression of the port b block
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1, powerOnReset = 1'b1, regWr = 1'b0, regRd = 1'b0, memMoveAccess = 1'b0;
	logic canEnable = 1'b0, canTransmitPin = 1'b0, lowVoltageProgEntry = 1'b0;
	logic [7:0] configByteThreeHigh = 8'h02, regWrData = 8'h00, extEn = 8'h00, extVal = 8'h00;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regRdData, pinIn, pinOut, pinOe, pullupEn;
	logic portChangeIrq, portChangeWake, portChangePriority;
	int failCount = 0, checkCount = 0;
	always #20 clk = ~clk;
	port_b_gpio port_b_gpio_i (.clk, .srst, .powerOnReset, .configByteThreeHigh, .regAddr, .regWrData, .regWr, .regRd,
		.memMoveAccess, .regRdData, .pinIn, .pinOut, .pinOe, .pullupEn, .canEnable, .canTransmitPin,
		.lowVoltageProgEntry, .portChangeIrq, .portChangeWake, .portChangePriority);
	keypad_model keypad_model_i (.clk, .pinOut, .pinOe, .pullupEn, .extEn, .extVal, .pinIn);
	// ----
	// bus and compare helpers
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			failCount++;
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdData, exp);
	endtask : rd
	task automatic por(input logic [7:0] cfg);
		srst <= 1'b1;
		powerOnReset <= 1'b1;
		configByteThreeHigh <= cfg;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		powerOnReset <= 1'b0;
	endtask : por
	// pins pass two sync flops before the compare
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	task automatic conclude;
		$display("Checks %0d, errors %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	// ----
	// scenarios
	// ----
	task automatic testReset;
		extEn <= 8'hff;
		extVal <= 8'hff;
		por(8'h02);
		settle;
		chk(pinOe, 8'h00);
		chk(pullupEn, 8'h00);
		chk({7'h00, portChangePriority}, 8'h01);
		chk({7'h00, portChangeIrq}, 8'h00);
		rd(port_b_pkg::OFS_DIRECTION_CONTROL, 8'hff);
		rd(port_b_pkg::OFS_INTERRUPT_CONTROL_SECOND, 8'h81);
		rd(4'h9, 8'h00);
		rd(port_b_pkg::OFS_PIN_VALUE, 8'he0);
		wr(port_b_pkg::OFS_ANALOG_PIN_CONFIG, 8'h0f);
		rd(port_b_pkg::OFS_ANALOG_PIN_CONFIG, 8'h0f);
		rd(port_b_pkg::OFS_PIN_VALUE, 8'hff);
		por(8'h00);
		settle;
		rd(port_b_pkg::OFS_PIN_VALUE, 8'hff);
	endtask : testReset
	task automatic testDrive;
		extVal <= 8'h03;
		extEn <= 8'h0f;
		wr(port_b_pkg::OFS_OUTPUT_LATCH, 8'ha5);
		wr(port_b_pkg::OFS_DIRECTION_CONTROL, 8'h0f);
		chk(pinOe, 8'hf0);
		chk(pinOut, 8'ha5);
		settle;
		rd(port_b_pkg::OFS_PIN_VALUE, 8'ha3);
		rd(port_b_pkg::OFS_OUTPUT_LATCH, 8'ha5);
		wr(port_b_pkg::OFS_PIN_VALUE, 8'h5a);
		chk(pinOut, 8'h5a);
	endtask : testDrive
	task automatic testPull;
		wr(port_b_pkg::OFS_INTERRUPT_CONTROL_SECOND, 8'h01);
		chk(pullupEn, 8'h0f);
		canEnable <= 1'b1;
		lowVoltageProgEntry <= 1'b1;
		wr(port_b_pkg::OFS_DIRECTION_CONTROL, 8'hff);
		chk(pullupEn, 8'hdb);
		chk(pinOe, 8'h04);
		canTransmitPin <= 1'b1;
		#1 chk(pinOut & 8'h04, 8'h04);
		canEnable <= 1'b0;
		lowVoltageProgEntry <= 1'b0;
	endtask : testPull
	// key wake-up and flag clear; the port is read to end the mismatch
	task automatic testChange;
		extEn <= 8'h00;
		settle;
		rd(port_b_pkg::OFS_PIN_VALUE, 8'hff);
		wr(port_b_pkg::OFS_INTERRUPT_CONTROL_PRIMARY, 8'h08);
		extEn <= 8'h40;
		settle;
		chk({7'h00, portChangeIrq}, 8'h01);
		chk({7'h00, portChangeWake}, 8'h01);
		wr(port_b_pkg::OFS_INTERRUPT_CONTROL_PRIMARY, 8'h08);
		settle;
		chk({7'h00, portChangeIrq}, 8'h01);
		memMoveAccess <= 1'b1;
		wr(port_b_pkg::OFS_PIN_VALUE, 8'h00);
		memMoveAccess <= 1'b0;
		wr(port_b_pkg::OFS_INTERRUPT_CONTROL_PRIMARY, 8'h08);
		settle;
		chk({7'h00, portChangeIrq}, 8'h01);
		rd(port_b_pkg::OFS_PIN_VALUE, 8'hbf);
		wr(port_b_pkg::OFS_INTERRUPT_CONTROL_PRIMARY, 8'h08);
		chk({7'h00, portChangeIrq}, 8'h00);
		chk({7'h00, portChangeWake}, 8'h00);
		extEn <= 8'h42;
		wr(port_b_pkg::OFS_DIRECTION_CONTROL, 8'h7f);
		settle;
		chk({7'h00, portChangeIrq}, 8'h00);
	endtask : testChange
	initial begin
		testReset;
		testDrive;
		testPull;
		testChange;
		conclude;
	end
endmodule : tb_top
